/* File: common/tsd_defines.svh */
// Register offsets, field positions, reset values and codes of the terminal status display.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef TSD_DEFINES_SVH
`define TSD_DEFINES_SVH

`define TSD_AW              8
`define TSD_ADDR_CTRL       8'h00
`define TSD_ADDR_LINK       8'h04
`define TSD_ADDR_INWORD     8'h08
`define TSD_ADDR_OUTWORD    8'h0c
`define TSD_ADDR_SEG        8'h10
`define TSD_ADDR_NAV        8'h14

`define TSD_RESP_OKAY       2'h0
`define TSD_RESP_SLVERR     2'h2

`define TSD_CTRL_SCOPE_LSB  0
`define TSD_CTRL_SCOPE_MSB  1
`define TSD_CTRL_RESET      2'h0
`define TSD_SCOPE_FULL      2'h2

`define TSD_LINK_FORWARD    0
`define TSD_LINK_BWD        1
`define TSD_LINK_CLR        2
`define TSD_LINK_RESET      3'h0

`define TSD_MENU_IO         3'h4
`define TSD_MENU_RESET      3'h1
`define TSD_ITEM_TERM       3'h0
`define TSD_ITEM_COMM       3'h1
`define TSD_ITEM_LAST       3'h4

`define TSD_SEG_A           0
`define TSD_SEG_F           5
`define TSD_SEG_G           6
`define TSD_SEG_DP          7

`define TSD_HX_RELAY        8
`define TSD_HX_LINK_FORWARD  13
`define TSD_HX_LINK_BACKWARD 14
`define TSD_HX_CLR          15

`define TSD_SYNC_W          12

`endif

/* File: common/tsd_pkg.sv */
// Types shared by the terminal status display design.
// Assumes nothing of its surroundings.
`default_nettype none
package tsd_pkg;

  typedef enum logic [1:0] {
    TSD_MENU = 2'h0,
    TSD_LIST = 2'h1,
    TSD_ITEM = 2'h3
  } tsd_nav_e;

  typedef struct packed {
    logic [4:0] inputs_on;
    logic       transistor_output;
    logic       relay_make_contact;
  } tsd_term_s;

  typedef struct packed {
    logic link_clear;
    logic link_backward_command;
    logic link_forward_command;
  } tsd_link_s;

endpackage : tsd_pkg
`default_nettype wire

/* File: core/tsd_sync.sv */
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level; no word coherence is implied.
`default_nettype none
module tsd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // tsd_sync
`default_nettype wire

/* File: core/tsd_hexseg.sv */
// Turns a word into seven-segment patterns, one hexadecimal digit per display digit.
// Assumes segment order dp,g,f,e,d,c,b,a from bit 7 down; the result is combinational.
`default_nettype none
module tsd_hexseg #(
  parameter int DIGITS = 4
) (
  input  wire logic [4*DIGITS-1:0] word,
  output logic      [8*DIGITS-1:0] seg
);

  function automatic logic [7:0] glyph(input logic [3:0] n);
    unique case (n)
      4'h0: glyph = 8'h3f;
      4'h1: glyph = 8'h06;
      4'h2: glyph = 8'h5b;
      4'h3: glyph = 8'h4f;
      4'h4: glyph = 8'h66;
      4'h5: glyph = 8'h6d;
      4'h6: glyph = 8'h7d;
      4'h7: glyph = 8'h07;
      4'h8: glyph = 8'h7f;
      4'h9: glyph = 8'h6f;
      4'ha: glyph = 8'h77;
      4'hb: glyph = 8'h7c;
      4'hc: glyph = 8'h39;
      4'hd: glyph = 8'h5e;
      4'he: glyph = 8'h79;
      4'hf: glyph = 8'h71;
    endcase
  endfunction

  for (genvar i = 0; i < DIGITS; i++) begin : g_digit
    assign seg[8*i +: 8] = glyph(word[4*i +: 4]);
  end

endmodule // tsd_hexseg
`default_nettype wire

/* File: core/tsd_top.sv */
// Terminal status display: drive-terminal levels shown on a four-digit seven-segment monitor.
// Assumes pins are asynchronous to CLOCK and software uses the AXI4-Lite slave port.
//
// What this block does
// RULE_01: Rightmost digit segments a-e show forward, backward and three auxiliary inputs.
// RULE_02: Third digit segment a lights while the transistor output is closed.
// RULE_03: Leftmost digit segment a lights while relay common meets the make contact.
// RULE_04: Second digit f, g, dp show link forward, backward and fault-clear commands.
// RULE_05: Segments without a terminal stay dark in segment mode.
// RULE_06: Raw terminal levels are shown, never the logically inverted signal.
// RULE_07: An input is on when tied to the common chosen by the jumper.
// RULE_08: Inside an item the function key toggles segment and hexadecimal views.
// RULE_09: Program key goes item to list, then list to menu.
// RULE_10: Menus may change only when the menu scope setting is two.
// RULE_11: Hex input word holds forward in bit 0, backward bit 1, auxiliaries bits 2-4.
// RULE_12: Hex output word holds transistor in bit 0, relay make contact in bit 8.
// RULE_13: Terminals are sampled into registers and the display updates from them.
//
// Our own choices: the AXI4-Lite register port and the address map.
`include "tsd_defines.svh"
`default_nettype none
module tsd_top #(
  parameter int NUM_IN = 5,
  parameter int DIGITS = 4
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RST_N,
  input  wire logic [NUM_IN-1:0]    TERM_LEVEL,
  input  wire logic                 SOURCE_JUMPER,
  input  wire logic                 TRANSISTOR_CLOSED,
  input  wire logic                 RELAY_MAKE_CLOSED,
  input  wire logic                 KEY_UP,
  input  wire logic                 KEY_DOWN,
  input  wire logic                 KEY_FUNC,
  input  wire logic                 KEY_PRG,
  output logic      [8*DIGITS-1:0]  SEG,
  input  wire logic [`TSD_AW-1:0]   S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic      [1:0]           S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [`TSD_AW-1:0]   S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic      [31:0]          S_AXI_RDATA,
  output logic      [1:0]           S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY
);

  logic [`TSD_SYNC_W-1:0] pin_s;
  logic [NUM_IN-1:0]      lvl_s;
  logic                   src_s;
  logic                   tr_s;
  logic                   rly_s;
  logic [3:0]             key_s;
  logic [3:0]             key_q_r;
  logic [3:0]             press;
  tsd_pkg::tsd_term_s     term_r;
  tsd_pkg::tsd_link_s     link_r;
  tsd_pkg::tsd_nav_e      nav_r;
  logic [1:0]             scope_r;
  logic [2:0]             menu_r;
  logic [2:0]             item_r;
  logic                   hex_r;
  logic [15:0]            in_word;
  logic [15:0]            out_word;
  logic [15:0]            hex_word;
  logic [8*DIGITS-1:0]    hex_seg;
  logic [8*DIGITS-1:0]    seg_nxt;
  logic [8*DIGITS-1:0]    seg_r;

  tsd_sync #(.WIDTH(`TSD_SYNC_W)) u_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .d     ({KEY_PRG, KEY_FUNC, KEY_DOWN, KEY_UP, RELAY_MAKE_CLOSED, TRANSISTOR_CLOSED,
             SOURCE_JUMPER, TERM_LEVEL}),
    .q     (pin_s)
  );

  assign {key_s, rly_s, tr_s, src_s, lvl_s} = pin_s;
  assign press = key_s & ~key_q_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      key_q_r <= '0;
    end else begin
      key_q_r <= key_s;
    end
  end

  // A pin reads low when tied to the sink common and high when tied to the source common.
  // No logic-inversion setting is applied here, so an inverted input may look dark while active.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      term_r <= '0;
    end else begin
      term_r.inputs_on          <= src_s ? lvl_s : ~lvl_s; // see RULE_06 see RULE_07 see RULE_13
      term_r.transistor_output  <= tr_s;                   // see RULE_13
      term_r.relay_make_contact <= rly_s;                  // see RULE_13
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      nav_r  <= tsd_pkg::TSD_MENU;
      menu_r <= `TSD_MENU_RESET;
      item_r <= `TSD_ITEM_TERM;
      hex_r  <= 1'b0;
    end else begin
      unique case (nav_r)
        tsd_pkg::TSD_MENU: begin
          if (scope_r == `TSD_SCOPE_FULL && press[0]) begin
            menu_r <= menu_r + 3'h1; // see RULE_10
          end else if (scope_r == `TSD_SCOPE_FULL && press[1]) begin
            menu_r <= menu_r - 3'h1; // see RULE_10
          end else if (press[2] && menu_r == `TSD_MENU_IO) begin
            nav_r  <= tsd_pkg::TSD_LIST;
            item_r <= `TSD_ITEM_TERM;
          end
        end
        tsd_pkg::TSD_LIST: begin
          if (press[3]) begin
            nav_r <= tsd_pkg::TSD_MENU; // see RULE_09
          end else if (press[2]) begin
            nav_r <= tsd_pkg::TSD_ITEM;
            hex_r <= 1'b0;
          end else if (press[0]) begin
            item_r <= (item_r == `TSD_ITEM_LAST) ? `TSD_ITEM_TERM : item_r + 3'h1;
          end else if (press[1]) begin
            item_r <= (item_r == `TSD_ITEM_TERM) ? `TSD_ITEM_LAST : item_r - 3'h1;
          end
        end
        tsd_pkg::TSD_ITEM: begin
          if (press[3]) begin
            nav_r <= tsd_pkg::TSD_LIST; // see RULE_09
          end else if (press[2]) begin
            hex_r <= ~hex_r; // see RULE_08
          end
        end
        default: begin
          nav_r <= tsd_pkg::TSD_MENU;
        end
      endcase
    end
  end

  always_comb begin
    in_word                      = '0;
    in_word[NUM_IN-1:0]          = term_r.inputs_on; // see RULE_11
    in_word[`TSD_HX_LINK_FORWARD]  = link_r.link_forward_command;
    in_word[`TSD_HX_LINK_BACKWARD] = link_r.link_backward_command;
    in_word[`TSD_HX_CLR]         = link_r.link_clear;
    out_word                     = '0;
    out_word[0]                  = term_r.transistor_output;  // see RULE_12
    out_word[`TSD_HX_RELAY]      = term_r.relay_make_contact; // see RULE_12
  end

  // Menu and list show their own codes; analog items are not built and show blank.
  always_comb begin
    hex_word = '0;
    unique case (nav_r)
      tsd_pkg::TSD_MENU: hex_word = {13'h0, menu_r};
      tsd_pkg::TSD_LIST: hex_word = {1'b0, menu_r, 9'h0, item_r};
      tsd_pkg::TSD_ITEM: hex_word = (item_r == `TSD_ITEM_TERM) ? out_word : in_word;
      default:           hex_word = '0;
    endcase
  end

  tsd_hexseg #(.DIGITS(DIGITS)) u_hex (
    .word (hex_word),
    .seg  (hex_seg)
  );

  always_comb begin
    seg_nxt = '0; // see RULE_05
    if (nav_r != tsd_pkg::TSD_ITEM || hex_r) begin
      seg_nxt = (nav_r == tsd_pkg::TSD_ITEM && item_r > `TSD_ITEM_COMM) ? '0 : hex_seg;
    end else if (item_r <= `TSD_ITEM_COMM) begin
      seg_nxt[NUM_IN-1:0]     = term_r.inputs_on;           // see RULE_01
      seg_nxt[8+`TSD_SEG_F]   = link_r.link_forward_command;  // see RULE_04
      seg_nxt[8+`TSD_SEG_G]   = link_r.link_backward_command; // see RULE_04
      seg_nxt[8+`TSD_SEG_DP]  = link_r.link_clear;            // see RULE_04
      if (item_r == `TSD_ITEM_TERM) begin
        seg_nxt[16+`TSD_SEG_A] = term_r.transistor_output;  // see RULE_02
        seg_nxt[24+`TSD_SEG_A] = term_r.relay_make_contact; // see RULE_03
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      seg_r <= '0;
    end else begin
      seg_r <= seg_nxt; // see RULE_13
    end
  end

  assign SEG = seg_r;

  // Register slave: address and data are caught separately; the response needs both.
  logic              aw_have_r;
  logic              w_have_r;
  logic [`TSD_AW-1:0] aw_addr_r;
  logic [31:0]        w_data_r;
  logic              w_strb0_r;
  logic              wr_go;
  logic [31:0]        rd_mux;
  logic              rd_hit;

  assign S_AXI_AWREADY = !aw_have_r && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_have_r && !S_AXI_BVALID;
  assign wr_go         = aw_have_r && w_have_r && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      w_have_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb0_r <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_r  <= 1'b1;
      w_data_r  <= S_AXI_WDATA;
      w_strb0_r <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      scope_r <= `TSD_CTRL_RESET;
      link_r  <= `TSD_LINK_RESET;
    end else if (wr_go && w_strb0_r) begin
      if (aw_addr_r == `TSD_ADDR_CTRL) begin
        scope_r <= w_data_r[`TSD_CTRL_SCOPE_MSB:`TSD_CTRL_SCOPE_LSB];
      end else if (aw_addr_r == `TSD_ADDR_LINK) begin
        link_r.link_forward_command  <= w_data_r[`TSD_LINK_FORWARD];
        link_r.link_backward_command <= w_data_r[`TSD_LINK_BWD];
        link_r.link_clear            <= w_data_r[`TSD_LINK_CLR];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `TSD_RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (aw_addr_r == `TSD_ADDR_CTRL || aw_addr_r == `TSD_ADDR_LINK) ?
                      `TSD_RESP_OKAY : `TSD_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (S_AXI_ARADDR)
      `TSD_ADDR_CTRL:    rd_mux = {30'h0, scope_r};
      `TSD_ADDR_LINK:    rd_mux = {29'h0, link_r};
      `TSD_ADDR_INWORD:  rd_mux = {16'h0, in_word};
      `TSD_ADDR_OUTWORD: rd_mux = {16'h0, out_word};
      `TSD_ADDR_SEG:     rd_mux = seg_r;
      `TSD_ADDR_NAV:     rd_mux = {22'h0, hex_r, 1'b0, item_r, menu_r, nav_r};
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= `TSD_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_mux;
      S_AXI_RRESP  <= rd_hit ? `TSD_RESP_OKAY : `TSD_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  logic seg_view;
  assign seg_view = nav_r == tsd_pkg::TSD_ITEM && !hex_r && item_r == `TSD_ITEM_TERM;

  a_run_input_seg : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_01
    $past(seg_view) |-> SEG[NUM_IN-1:0] == $past(term_r.inputs_on))
    else $error("input segments do not follow sampled inputs");
  a_transistor_seg : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_02
    $past(seg_view) |-> SEG[16+`TSD_SEG_A] == $past(term_r.transistor_output))
    else $error("third digit segment a wrong");
  a_relay_seg : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_03
    $past(seg_view) |-> SEG[24+`TSD_SEG_A] == $past(term_r.relay_make_contact))
    else $error("leftmost digit segment a wrong");
  a_link_cmd_seg : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_04
    $past(seg_view) |-> SEG[15:13] == $past(link_r))
    else $error("second digit link segments wrong");
  a_dark_unused : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_05
    $past(seg_view) |-> SEG[7:NUM_IN] == '0 && SEG[12:8] == '0 && SEG[23:17] == '0 && SEG[31:25] == '0)
    else $error("unassigned segment lit");
  a_jumper_sense : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_07
    $past(RST_N) |-> term_r.inputs_on == ($past(src_s) ? $past(lvl_s) : ~$past(lvl_s)))
    else $error("input on-state ignores jumper");
  a_mode_toggle : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_08
    nav_r == tsd_pkg::TSD_ITEM && press[2] && !press[3] |=> hex_r != $past(hex_r))
    else $error("function key did not toggle view");
  a_prg_back : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_09
    press[3] && nav_r != tsd_pkg::TSD_MENU |=>
    nav_r == (($past(nav_r) == tsd_pkg::TSD_ITEM) ? tsd_pkg::TSD_LIST : tsd_pkg::TSD_MENU))
    else $error("program key did not step back");
  a_scope_lock : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_10
    scope_r != `TSD_SCOPE_FULL |=> $stable(menu_r))
    else $error("menu changed outside full scope");
  a_hex_layout : assert property (@(posedge CLOCK) disable iff (!RST_N) // see RULE_11 see RULE_12
    in_word[12:NUM_IN] == '0 && out_word[0] == term_r.transistor_output &&
    out_word[`TSD_HX_RELAY] == term_r.relay_make_contact && in_word[0] == term_r.inputs_on[0])
    else $error("hex status word layout wrong");

endmodule // tsd_top
`default_nettype wire

/* File: dv/tb_terminal_status_segment_display.sv */
// Self-checking bench for the terminal status display top: AXI4-Lite tasks, key presses and pin patterns.
// Assumes the shared package, defines header and design modules are compiled before this file.
`include "tsd_defines.svh"
`default_nettype none
module tb_terminal_status_segment_display;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        rst_n;
  logic [4:0]  lvl;
  logic        jmp, tcl, rcl;
  logic [3:0]  keys;
  logic [31:0] seg;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [4:0]  on;
  logic [2:0]  lk;
  int          errors, compares;

  tsd_top #(.NUM_IN(5), .DIGITS(4)) DUT (
    .CLOCK             (clock),
    .RST_N             (rst_n),
    .TERM_LEVEL        (lvl),
    .SOURCE_JUMPER     (jmp),
    .TRANSISTOR_CLOSED (tcl),
    .RELAY_MAKE_CLOSED (rcl),
    .KEY_UP            (keys[0]),
    .KEY_DOWN          (keys[1]),
    .KEY_FUNC          (keys[2]),
    .KEY_PRG           (keys[3]),
    .SEG               (seg),
    .S_AXI_AWADDR      (awaddr),
    .S_AXI_AWVALID     (awvalid),
    .S_AXI_AWREADY     (awready),
    .S_AXI_WDATA       (wdata),
    .S_AXI_WSTRB       (wstrb),
    .S_AXI_WVALID      (wvalid),
    .S_AXI_WREADY      (wready),
    .S_AXI_BRESP       (bresp),
    .S_AXI_BVALID      (bvalid),
    .S_AXI_BREADY      (bready),
    .S_AXI_ARADDR      (araddr),
    .S_AXI_ARVALID     (arvalid),
    .S_AXI_ARREADY     (arready),
    .S_AXI_RDATA       (rdata),
    .S_AXI_RRESP       (rresp),
    .S_AXI_RVALID      (rvalid),
    .S_AXI_RREADY      (rready)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, where combinational ready has settled for the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb, done;
    int   n;
    done = 1'b0;
    n = 0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done && n < 200) begin
      @(negedge clock);
      n++;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb) rsp = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) check(32'h0, 32'hdead);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr, done;
    int   n;
    done = 1'b0;
    n = 0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done && n < 200) begin
      @(negedge clock);
      n++;
      ta = arvalid && arready;
      tr = rvalid && rready;
      if (tr) begin
        rdv = rdata;
        rsp = rresp;
      end
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) check(32'h0, 32'hdead);
  endtask

  // A press is one high cycle, then enough low cycles for the synchroniser and edge detector.
  task automatic press(input int k);
    @(posedge clock);
    keys[k] <= 1'b1;
    @(posedge clock);
    keys <= 4'h0;
    repeat (6) @(posedge clock);
  endtask

  function automatic logic [7:0] hx(input logic [3:0] v);
    case (v)
      4'h0: hx = 8'h3f;
      4'h1: hx = 8'h06;
      4'h2: hx = 8'h5b;
      4'h3: hx = 8'h4f;
      4'h4: hx = 8'h66;
      4'h5: hx = 8'h6d;
      default: hx = 8'h7f;
    endcase
  endfunction

  function automatic logic [31:0] hw(input logic [15:0] w);
    hw = {hx(w[15:12]), hx(w[11:8]), hx(w[7:4]), hx(w[3:0])};
  endfunction

  function automatic logic [31:0] seg_exp(input logic it1);
    seg_exp = {7'h0, rcl & ~it1, 7'h0, tcl & ~it1, lk[2], lk[1], lk[0], 5'h0, 3'h0, on};
  endfunction

  task automatic set_pins(input logic [4:0] l, input logic j, input logic t, input logic r, input logic [2:0] k);
    @(posedge clock);
    lvl <= l;
    jmp <= j;
    tcl <= t;
    rcl <= r;
    lk = k;
    on = j ? l : ~l;
    wr(`TSD_ADDR_LINK, {29'h0, k}, 4'hf);
    repeat (6) @(posedge clock);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    print_verdict();
  end

  initial begin
    rst_n    = 1'b0;
    lvl      = 5'h0;
    jmp      = 1'b0;
    tcl      = 1'b0;
    rcl      = 1'b0;
    keys     = 4'h0;
    awaddr   = 8'h0;
    araddr   = 8'h0;
    wdata    = 32'h0;
    wstrb    = 4'h0;
    awvalid  = 1'b0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    arvalid  = 1'b0;
    rready   = 1'b0;
    errors   = 0;
    compares = 0;
    lk       = 3'h0;
    on       = 5'h0;
    repeat (10) @(posedge clock);
    check(seg, 32'h0);
    rst_n <= 1'b1;
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h4);
    rd(`TSD_ADDR_CTRL);
    check(rdv, 32'h0);
    rd(8'h20);
    check({rdv[29:0], rsp}, {30'h0, `TSD_RESP_SLVERR});
    wr(8'h20, 32'h2, 4'hf);
    check({30'h0, rsp}, {30'h0, `TSD_RESP_SLVERR});
    press(0);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h4);
    wr(`TSD_ADDR_CTRL, 32'h2, 4'h0);
    rd(`TSD_ADDR_CTRL);
    check(rdv, 32'h0);
    wr(`TSD_ADDR_CTRL, 32'h2, 4'hf);
    check({30'h0, rsp}, 32'h0);
    rd(`TSD_ADDR_CTRL);
    check(rdv, 32'h2);
    repeat (3) press(0);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h10);
    press(2);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h11);
    press(2);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h13);
    for (int i = 0; i < 8; i++) begin
      set_pins(5'(i * 5) ^ 5'h0a, i[0], i[1], i[2], 3'(i));
      check(seg, seg_exp(1'b0));
      rd(`TSD_ADDR_SEG);
      check(rdv, seg_exp(1'b0));
      rd(`TSD_ADDR_INWORD);
      check(rdv, {16'h0, lk, 8'h0, on});
      rd(`TSD_ADDR_OUTWORD);
      check(rdv, {23'h0, rcl, 7'h0, tcl});
    end
    press(2);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h213);
    check(seg, hw(16'h0101));
    press(2);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h13);
    press(3);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h11);
    press(0);
    press(2);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h33);
    set_pins(5'h0c, 1'b0, 1'b1, 1'b1, 3'h1);
    check(seg, seg_exp(1'b1));
    press(2);
    check(seg, hw(16'h2013));
    press(2);
    press(3);
    press(0);
    press(2);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h53);
    check(seg, 32'h0);
    press(3);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h51);
    // The down key is walked as well: item 2 steps back to item 1 in the list.
    press(1);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h31);
    check(seg, hw(16'h4001));
    // Leaving the list keeps the item number, so the NAV register still reports item 1 while the menu view shows menu 4.
    press(3);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h30);
    check(seg, hw(16'h0004));
    press(1);
    rd(`TSD_ADDR_NAV);
    check(rdv, 32'h2c);
    print_verdict();
  end
endmodule // tb_terminal_status_segment_display
`default_nettype wire
